// ===== verilog/acsu_defs.svh
// Purpose: Constants of the atomic conditional store unit.
// Assumes: Included by its bare name from the top module.
// Notes: Definitions only.
`ifndef ACSU_DEFS_SVH
`define ACSU_DEFS_SVH

// Special-register numbers.
`define ACSU_SR_CMP 8'h0C
`define ACSU_SR_ROUTE 8'h63

// Routing field positions.
`define ACSU_BACK_MSB 5
`define ACSU_BACK_LSB 4
`define ACSU_THRU_MSB 3
`define ACSU_THRU_LSB 2
`define ACSU_UNC_MSB 1
`define ACSU_UNC_LSB 0

// Routing codes.
`define ACSU_CODE_EXC 2'h0
`define ACSU_CODE_BUS 2'h1
`define ACSU_CODE_INT 2'h2

// Reset value of the routing register and the fixed routing used without it.
`define ACSU_ROUTE_RST 6'h15
`define ACSU_ROUTE_FIXED 6'h15

// Exception cause reported for the atomic instruction.
`define ACSU_CAUSE_LSERR 6'h03

// Memory types of an atomic access.
`define ACSU_MT_LOCAL 2'h0
`define ACSU_MT_BACK 2'h1
`define ACSU_MT_THRU 2'h2
`define ACSU_MT_UNC 2'h3

// Reset value of the comparison register; its contents are not defined for software.
`define ACSU_CMP_RST 32'h00000000

`endif

// ===== verilog/acsu_pkg.sv
// Purpose: Types of the atomic conditional store unit.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are one-hot.
`default_nettype none
package acsu_pkg;

  typedef enum logic [7:0] {
    ACSU_S_IDLE = 8'h01,
    ACSU_S_RD = 8'h02,
    ACSU_S_CMP = 8'h04,
    ACSU_S_WR = 8'h08,
    ACSU_S_FLUSH = 8'h10,
    ACSU_S_BUS = 8'h20,
    ACSU_S_CACHE = 8'h40
  } acsu_state_t;

  typedef enum logic [1:0] {
    ACSU_M_EXC = 2'h0,
    ACSU_M_BUS = 2'h1,
    ACSU_M_INT = 2'h2
  } acsu_meth_t;

  typedef enum logic [1:0] {
    ACSU_SR_READ = 2'h0,
    ACSU_SR_WRITE = 2'h1,
    ACSU_SR_EXCH = 2'h2
  } acsu_srop_t;

  typedef struct packed {
    acsu_state_t st;
    logic inb;
    logic [31:0] addr;
    logic [31:0] cmp;
    logic [31:0] wdata;
    logic [31:0] old;
    logic [31:0] cmp_reg;
    logic [5:0] route;
    logic sr_ack;
    logic [31:0] sr_rdata;
    logic dram_en;
    logic dram_we;
    logic flush_req;
    logic bus_req;
    logic cache_req;
    logic atom_done;
    logic atom_exc;
    logic [5:0] cause;
    logic in_done;
    logic hold;
  } acsu_regs_t;

endpackage
`default_nettype wire

// ===== verilog/acsu_top.sv
// Purpose: Atomic compare-and-conditional-store unit with its special registers.
// Assumes: All inputs synchronous to clk; request inputs held until their done pulse.
// Notes: Local data RAM has one cycle of read latency.
//
// Behaviour
// - Store only on match, indivisibly.
// - Always return the old memory word; in exception mode atom_old_data keeps its previous value.
// - Comparison register at special number 12.
// - Six-bit routing register at number 99.
// - Registers reached only by special instructions.
// - Local RAM addresses handled directly on RAM.
// - Exception mode raises error, no access.
// - Exception cause code is binary 000011.
// - Bus mode issues dedicated read-compare-write.
// - Flush cached line before bus transaction.
// - Inbound transaction executes atomically on RAM.
// - Internal mode runs atomically in cache.
// - Bits 5:4 route writeback memory.
// - Bits 3:2 route writethrough memory.
// - Bits 1:0 route uncached memory.
// - Values 0x15 and 0x01 behave as documented.
// - All routing fields store any value.
// - Routing ignored for local RAM, inbound.
// - Without routing register, fixed method per type.
// - Wait for earlier accesses before starting.
// - Hold later accesses until pair performs.
// - Comparison register undefined for software after reset.
`timescale 1ns/10ps
`default_nettype none
`include "acsu_defs.svh"

module acsu_top
  import acsu_pkg::*;
#(
  parameter bit HAS_ROUTE_CTRL = 1'b1,
  parameter bit HAS_INTERNAL_THRU = 1'b1
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sr_valid,
  input wire logic [1:0] sr_op,
  input wire logic [7:0] sr_num,
  input wire logic [31:0] sr_wdata,
  output logic sr_ack,
  output logic [31:0] sr_rdata,
  input wire logic atom_req,
  input wire logic [1:0] atom_mem_type,
  input wire logic [31:0] atom_addr,
  input wire logic [31:0] atom_store_data,
  input wire logic ord_pending,
  output logic order_hold,
  output logic atom_done,
  output logic atom_exc,
  output logic [5:0] atom_exc_cause,
  output logic [31:0] atom_old_data,
  input wire logic in_req,
  input wire logic [31:0] in_addr,
  input wire logic [31:0] in_cmp,
  input wire logic [31:0] in_data,
  output logic in_done,
  output logic [31:0] in_old_data,
  output logic dram_en,
  output logic dram_we,
  output logic [31:0] dram_addr,
  output logic [31:0] dram_wdata,
  input wire logic [31:0] dram_rdata,
  output logic flush_req,
  output logic [31:0] flush_addr,
  input wire logic flush_ack,
  output logic read_compare_write_txn,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_cmp,
  output logic [31:0] bus_data,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  output logic cache_req,
  output logic [31:0] cache_addr,
  output logic [31:0] cache_cmp,
  output logic [31:0] cache_data,
  input wire logic cache_ack,
  input wire logic [31:0] cache_rdata
);

  acsu_regs_t r;
  acsu_regs_t next_r;
  logic [5:0] route_eff;

  // Maps a cached or uncached memory type and a routing value to a method.
  // Local RAM never reaches here; it is steered before routing is consulted.
  function automatic acsu_meth_t acsu_method(input logic [1:0] mtype, input logic [5:0] route);
    acsu_meth_t m;
    m = ACSU_M_EXC;
    case (mtype)
      `ACSU_MT_BACK:
      begin
        if (route[`ACSU_BACK_MSB:`ACSU_BACK_LSB] == `ACSU_CODE_BUS)
          m = ACSU_M_BUS;
        else if (route[`ACSU_BACK_MSB:`ACSU_BACK_LSB] == `ACSU_CODE_INT)
          m = ACSU_M_INT;
      end
      `ACSU_MT_THRU:
      begin
        if (route[`ACSU_THRU_MSB:`ACSU_THRU_LSB] == `ACSU_CODE_BUS)
          m = ACSU_M_BUS;
        else if (route[`ACSU_THRU_MSB:`ACSU_THRU_LSB] == `ACSU_CODE_INT
                 && HAS_INTERNAL_THRU)
          m = ACSU_M_INT;
      end
      `ACSU_MT_UNC:
      begin
        if (route[`ACSU_UNC_MSB:`ACSU_UNC_LSB] == `ACSU_CODE_BUS)
          m = ACSU_M_BUS;
      end
      default:
        m = ACSU_M_EXC;
    endcase
    // Reserved codes and code 0 both fall through to the exception method.
    return m;
  endfunction

  // True for memory whose lines may sit in the data cache.
  function automatic logic acsu_cacheable(input logic [1:0] mtype);
    return (mtype == `ACSU_MT_BACK) || (mtype == `ACSU_MT_THRU);
  endfunction

  // A core without the routing register uses one fixed method per type.
  // The fixed value equals the reset value, so software sees one routing either way.
  assign route_eff = HAS_ROUTE_CTRL ? r.route : `ACSU_ROUTE_FIXED;

  always_comb
  begin
    next_r = r;
    next_r.sr_ack = 1'b0;
    next_r.atom_done = 1'b0;
    next_r.atom_exc = 1'b0;
    next_r.in_done = 1'b0;

    // Special-register read, write and exchange are the only access path.
    if (sr_valid)
    begin
      next_r.sr_ack = 1'b1;
      next_r.sr_rdata = 32'h00000000;
      case (sr_num)
        `ACSU_SR_CMP:
        begin
          next_r.sr_rdata = r.cmp_reg;
          if (sr_op == ACSU_SR_WRITE || sr_op == ACSU_SR_EXCH)
            next_r.cmp_reg = sr_wdata;
        end
        `ACSU_SR_ROUTE:
        begin
          if (HAS_ROUTE_CTRL)
          begin
            // Reserved upper bits read as zero; every field keeps any value.
            next_r.sr_rdata = {26'h0000000, r.route};
            if (sr_op == ACSU_SR_WRITE || sr_op == ACSU_SR_EXCH)
              next_r.route = sr_wdata[5:0];
          end
        end
        default:
          next_r.sr_rdata = 32'h00000000;
      endcase
    end

    case (r.st)
      ACSU_S_IDLE:
      begin
        // Skipping the cycle of a done pulse lets the requester drop its request.
        if (!r.atom_done && !r.in_done)
        begin
          if (in_req)
          begin
            // Inbound transactions never consult the routing register.
            next_r.inb = 1'b1;
            next_r.addr = in_addr;
            next_r.cmp = in_cmp;
            next_r.wdata = in_data;
            next_r.dram_en = 1'b1;
            next_r.dram_we = 1'b0;
            next_r.st = ACSU_S_RD;
          end
          else if (atom_req && !ord_pending)
          begin
            next_r.inb = 1'b0;
            next_r.hold = 1'b1;
            next_r.addr = atom_addr;
            next_r.cmp = r.cmp_reg;
            next_r.wdata = atom_store_data;
            if (atom_mem_type == `ACSU_MT_LOCAL)
            begin
              next_r.dram_en = 1'b1;
              next_r.dram_we = 1'b0;
              next_r.st = ACSU_S_RD;
            end
            else
            begin
              case (acsu_method(atom_mem_type, route_eff))
                ACSU_M_BUS:
                begin
                  if (acsu_cacheable(atom_mem_type))
                  begin
                    next_r.flush_req = 1'b1;
                    next_r.st = ACSU_S_FLUSH;
                  end
                  else
                  begin
                    next_r.bus_req = 1'b1;
                    next_r.st = ACSU_S_BUS;
                  end
                end
                ACSU_M_INT:
                begin
                  next_r.cache_req = 1'b1;
                  next_r.st = ACSU_S_CACHE;
                end
                default:
                begin
                  // No memory access at all; the error is reported at once.
                  next_r.atom_exc = 1'b1;
                  next_r.atom_done = 1'b1;
                  next_r.cause = `ACSU_CAUSE_LSERR;
                  next_r.hold = 1'b0;
                end
              endcase
            end
          end
        end
      end
      ACSU_S_RD:
      begin
        next_r.dram_en = 1'b0;
        next_r.st = ACSU_S_CMP;
      end
      ACSU_S_CMP:
      begin
        // The RAM is owned from read to write, so nothing slips in between.
        next_r.old = dram_rdata;
        if (dram_rdata == r.cmp)
        begin
          next_r.dram_en = 1'b1;
          next_r.dram_we = 1'b1;
        end
        next_r.st = ACSU_S_WR;
      end
      ACSU_S_WR:
      begin
        next_r.dram_en = 1'b0;
        next_r.dram_we = 1'b0;
        next_r.st = ACSU_S_IDLE;
        next_r.hold = 1'b0;
        next_r.in_done = r.inb;
        next_r.atom_done = !r.inb;
      end
      ACSU_S_FLUSH:
      begin
        // The line must be written back before the far end reads the word.
        if (flush_ack)
        begin
          next_r.flush_req = 1'b0;
          next_r.bus_req = 1'b1;
          next_r.st = ACSU_S_BUS;
        end
      end
      ACSU_S_BUS:
      begin
        // The far end performs the compare and write on the target word.
        // A slow answer only stretches order_hold; there is no time limit here.
        if (bus_ack)
        begin
          next_r.bus_req = 1'b0;
          next_r.old = bus_rdata;
          next_r.st = ACSU_S_IDLE;
          next_r.hold = 1'b0;
          next_r.atom_done = 1'b1;
        end
      end
      ACSU_S_CACHE:
      begin
        if (cache_ack)
        begin
          next_r.cache_req = 1'b0;
          next_r.old = cache_rdata;
          next_r.st = ACSU_S_IDLE;
          next_r.hold = 1'b0;
          next_r.atom_done = 1'b1;
        end
      end
      default:
      begin
        next_r.st = ACSU_S_IDLE;
        next_r.dram_en = 1'b0;
        next_r.dram_we = 1'b0;
        next_r.flush_req = 1'b0;
        next_r.bus_req = 1'b0;
        next_r.cache_req = 1'b0;
        next_r.hold = 1'b0;
      end
    endcase
  end

  // The comparison register is cleared only for tidiness; software must write it first.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.st <= ACSU_S_IDLE;
      r.route <= `ACSU_ROUTE_RST;
      r.cmp_reg <= `ACSU_CMP_RST;
    end
    else
      r <= next_r;
  end

  assign sr_ack = r.sr_ack;
  assign sr_rdata = r.sr_rdata;
  assign order_hold = r.hold;
  assign atom_done = r.atom_done;
  assign atom_exc = r.atom_exc;
  assign atom_exc_cause = r.cause;
  assign atom_old_data = r.old;
  assign in_done = r.in_done;
  assign in_old_data = r.old;
  assign dram_en = r.dram_en;
  assign dram_we = r.dram_we;
  assign dram_addr = r.addr;
  assign dram_wdata = r.wdata;
  assign flush_req = r.flush_req;
  assign flush_addr = r.addr;
  assign read_compare_write_txn = r.bus_req;
  assign bus_addr = r.addr;
  assign bus_cmp = r.cmp;
  assign bus_data = r.wdata;
  assign cache_req = r.cache_req;
  assign cache_addr = r.addr;
  assign cache_cmp = r.cmp;
  assign cache_data = r.wdata;

endmodule // acsu_top
`default_nettype wire

// ===== tb/acsu_asserts.sv
// Purpose: Concurrent checks on the ports of the atomic unit.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Attached to every instance of the top module.
`timescale 1ns/10ps
`default_nettype none
module acsu_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sr_valid,
  input wire logic sr_ack,
  input wire logic ord_pending,
  input wire logic order_hold,
  input wire logic atom_done,
  input wire logic atom_exc,
  input wire logic [5:0] atom_exc_cause,
  input wire logic [1:0] atom_mem_type,
  input wire logic [31:0] atom_addr,
  input wire logic [31:0] atom_old_data,
  input wire logic dram_en,
  input wire logic dram_we,
  input wire logic flush_req,
  input wire logic [31:0] flush_addr,
  input wire logic flush_ack,
  input wire logic read_compare_write_txn,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic cache_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic quiet;
  assign quiet = !read_compare_write_txn && !cache_req && !flush_req;
  sequence s_local;
    (quiet && !atom_done)[*3] ##1 (quiet && atom_done);
  endsequence
  sr_ack_a: assert property (sr_valid |=> sr_ack)
    else $error("special register access not acknowledged");
  exc_cause_a: assert property (atom_exc |-> atom_done && atom_exc_cause == 6'h03)
    else $error("exception without done or with wrong cause");
  exc_noaccess_a: assert property (atom_exc |-> !order_hold && $past(quiet && !dram_en))
    else $error("exception mode touched memory");
  order_wait_a: assert property ($rose(order_hold) |-> $past(!ord_pending))
    else $error("atomic started before earlier accesses performed");
  hold_release_a: assert property ($fell(order_hold) |-> atom_done)
    else $error("later accesses released before completion");
  local_path_a: assert property ($rose(order_hold) && atom_mem_type == 2'h0 |-> s_local)
    else $error("local memory atomic left the local path");
  flush_first_a: assert property ($rose(read_compare_write_txn) && atom_mem_type != 2'h3
    |-> $past(flush_ack))
    else $error("cacheable transaction sent without flush");
  flush_addr_a: assert property (flush_req |-> flush_addr == atom_addr)
    else $error("flush sent for another address");
  bus_old_a: assert property (read_compare_write_txn && bus_ack |=> atom_done
    && atom_old_data == $past(bus_rdata))
    else $error("bus old word not returned");
  dram_write_a: assert property (dram_en && dram_we |-> $past(dram_en && !dram_we, 2))
    else $error("local write without preceding read");
endmodule // acsu_asserts
bind acsu_top acsu_asserts u_chk (.clk, .rstn, .sr_valid, .sr_ack, .ord_pending, .order_hold,
  .atom_done, .atom_exc, .atom_exc_cause, .atom_mem_type, .atom_addr, .atom_old_data, .dram_en,
  .dram_we, .flush_req, .flush_addr, .flush_ack, .read_compare_write_txn, .bus_ack, .bus_rdata,
  .cache_req);
`default_nettype wire

// ===== tb/acsu_far_model.sv
// Purpose: Far-side memory, bus and cache model for the atomic unit.
// Assumes: Requests are levels held until their acknowledge.
// Notes: Word i starts as 32'hA0000000 plus i; lat sets the answer delay.
`timescale 1ns/10ps
`default_nettype none
module acsu_far_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic dram_en,
  input wire logic dram_we,
  input wire logic [31:0] dram_addr,
  input wire logic [31:0] dram_wdata,
  output logic [31:0] dram_rdata,
  input wire logic flush_req,
  output logic flush_ack,
  input wire logic read_compare_write_txn,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_cmp,
  input wire logic [31:0] bus_data,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  input wire logic cache_req,
  input wire logic [31:0] cache_addr,
  input wire logic [31:0] cache_cmp,
  input wire logic [31:0] cache_data,
  output logic cache_ack,
  output logic [31:0] cache_rdata
);
  logic [31:0] mem [16];
  logic [31:0] cv, wv;
  logic [3:0] ix, cnt;
  logic ack;
  assign ix = read_compare_write_txn ? bus_addr[5:2] : cache_addr[5:2];
  assign cv = read_compare_write_txn ? bus_cmp : cache_cmp;
  assign wv = read_compare_write_txn ? bus_data : cache_data;
  assign flush_ack = ack && flush_req;
  assign bus_ack = ack && read_compare_write_txn;
  assign cache_ack = ack && cache_req;
  assign cache_rdata = bus_rdata;
  initial for (int i = 0; i < 16; i++) mem[i] = 32'hA0000000 | 32'(i);
  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      cnt <= 4'h0;
      ack <= 1'b0;
      dram_rdata <= 32'h0;
      bus_rdata <= 32'h0;
    end
    else
    begin
      // Idle data lines toggle so that a stale word never passes for an answer.
      dram_rdata <= (dram_en && !dram_we) ? mem[dram_addr[5:2]] : ~dram_rdata;
      bus_rdata <= ~bus_rdata;
      ack <= 1'b0;
      if (dram_en && dram_we)
        mem[dram_addr[5:2]] <= dram_wdata;
      if (ack)
        cnt <= 4'h0;
      else if (flush_req || read_compare_write_txn || cache_req)
      begin
        cnt <= cnt + 4'h1;
        if (cnt == lat)
        begin
          ack <= 1'b1;
          bus_rdata <= mem[ix];
          if (!flush_req && mem[ix] == cv)
            mem[ix] <= wv;
        end
      end
    end
endmodule // acsu_far_model
`default_nettype wire

// ===== tb/acsu_top_tb.sv
// Purpose: Self-checking bench for the atomic conditional store unit.
// Assumes: Far-side words start as 32'hA0000000 plus their index.
// Notes: Outputs are read just after a rising edge, before its updates land.
`timescale 1ns/10ps
`default_nettype none
module acsu_top_tb;
  logic clk = 0, rstn = 0, sr_valid = 0, atom_req = 0, ord_pending = 0, in_req = 0;
  logic [1:0] sr_op = 0, atom_mem_type = 0;
  logic [7:0] sr_num = 0;
  logic [31:0] sr_wdata = 0, atom_addr = 0, atom_store_data = 0, in_addr = 0, in_cmp = 0;
  logic [31:0] in_data = 0, r, o, sr_rdata, atom_old_data, in_old_data, dram_addr, dram_wdata;
  logic [31:0] dram_rdata, bus_addr, bus_cmp, bus_data, bus_rdata;
  logic [31:0] cache_addr, cache_cmp, cache_data, cache_rdata;
  logic [3:0] lat = 0;
  logic [5:0] atom_exc_cause;
  logic sr_ack, order_hold, atom_done, atom_exc, in_done, dram_en, dram_we, flush_req, e;
  logic flush_ack, read_compare_write_txn, bus_ack, cache_req, cache_ack, saw_b, saw_c, saw_f;
  int bad_count = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    saw_b = saw_b | read_compare_write_txn;
    saw_c = saw_c | cache_req;
    saw_f = saw_f | flush_req;
  end
  acsu_top uut (.clk, .rstn, .sr_valid, .sr_op, .sr_num, .sr_wdata, .sr_ack, .sr_rdata,
    .atom_req, .atom_mem_type, .atom_addr, .atom_store_data, .ord_pending, .order_hold,
    .atom_done, .atom_exc, .atom_exc_cause, .atom_old_data, .in_req, .in_addr, .in_cmp,
    .in_data, .in_done, .in_old_data, .dram_en, .dram_we, .dram_addr, .dram_wdata,
    .dram_rdata, .flush_req, .flush_addr(), .flush_ack, .read_compare_write_txn, .bus_addr,
    .bus_cmp, .bus_data, .bus_ack, .bus_rdata, .cache_req, .cache_addr, .cache_cmp,
    .cache_data, .cache_ack, .cache_rdata);
  acsu_far_model far (.clk, .rstn, .lat, .dram_en, .dram_we, .dram_addr, .dram_wdata,
    .dram_rdata, .flush_req, .flush_ack, .read_compare_write_txn, .bus_addr, .bus_cmp,
    .bus_data, .bus_ack, .bus_rdata, .cache_req, .cache_addr, .cache_cmp, .cache_data,
    .cache_ack, .cache_rdata);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic sr(input logic [1:0] op, input logic [7:0] n, input logic [31:0] wd);
    sr_valid <= 1'b1;
    sr_op <= op;
    sr_num <= n;
    sr_wdata <= wd;
    @(posedge clk);
    sr_valid <= 1'b0;
    @(posedge clk);
    chk("sr_ack", {31'h0, sr_ack}, 32'h1);
    r = sr_rdata;
  endtask
  task automatic atom(input logic [1:0] mt, input logic [31:0] d, input int pend);
    saw_b = 0;
    saw_c = 0;
    saw_f = 0;
    atom_req <= 1'b1;
    atom_mem_type <= mt;
    atom_addr <= (mt == 2'h0) ? 32'h4 : 32'h8;
    atom_store_data <= d;
    ord_pending <= (pend > 0);
    repeat (pend) @(posedge clk);
    chk("hold", {31'h0, order_hold}, 32'h0);
    if (pend > 0)
      ord_pending <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 60 && atom_done !== 1'b1; i++) @(posedge clk);
    chk("done", {31'h0, atom_done}, 32'h1);
    o = atom_old_data;
    e = atom_exc;
    atom_req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic inb(input logic [31:0] c, input logic [31:0] d, input logic [31:0] x);
    in_req <= 1'b1;
    in_addr <= 32'h4;
    in_cmp <= c;
    in_data <= d;
    @(posedge clk);
    for (int i = 0; i < 20 && in_done !== 1'b1; i++) @(posedge clk);
    chk("in done", {31'h0, in_done}, 32'h1);
    chk("in old", in_old_data, x);
    in_req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs;
    sr(2'h0, 8'h63, 32'h0);
    chk("route reset", r, 32'h15);
    sr(2'h1, 8'h63, 32'hFFFFFFFF);
    sr(2'h0, 8'h63, 32'h0);
    chk("route bits", r, 32'h3F);
    sr(2'h1, 8'h0C, 32'hCAFE0001);
    sr(2'h2, 8'h0C, 32'hA0000001);
    chk("cmp exch", r, 32'hCAFE0001);
    sr(2'h1, 8'h20, 32'h1);
    sr(2'h0, 8'h20, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask
  task automatic t_local;
    sr(2'h1, 8'h63, 32'h0);
    atom(2'h0, 32'h12345678, 0);
    chk("local old", o, 32'hA0000001);
    chk("local exc", {31'h0, e}, 32'h0);
    atom(2'h0, 32'hDEAD0000, 3);
    chk("local new", o, 32'h12345678);
    atom(2'h0, 32'hDEAD0000, 0);
    chk("no store", o, 32'h12345678);
    inb(32'h12345678, 32'h55, 32'h12345678);
    inb(32'h0, 32'h66, 32'h55);
  endtask
  task automatic t_route;
    logic [5:0] rt [4] = '{6'h15, 6'h01, 6'h2A, 6'h3F};
    logic [1:0] f;
    logic bus, cac;
    sr(2'h1, 8'h0C, 32'hA0000002);
    foreach (rt[i])
    begin
      sr(2'h1, 8'h63, {26'h0, rt[i]});
      for (int m = 1; m < 4; m++)
      begin
        lat <= (m == 2) ? 4'h5 : 4'h0;
        f = (m == 1) ? rt[i][5:4] : (m == 2) ? rt[i][3:2] : rt[i][1:0];
        bus = (f == 2'h1);
        cac = (f == 2'h2) && (m != 3);
        atom(m[1:0], 32'hA0000002, 0);
        chk("exc", {31'h0, e}, {31'h0, !bus && !cac});
        chk("bus", {31'h0, saw_b}, {31'h0, bus});
        chk("cache", {31'h0, saw_c}, {31'h0, cac});
        chk("flush", {31'h0, saw_f}, {31'h0, bus && m != 3});
        if (bus || cac)
          chk("old", o, 32'hA0000002);
        else
          chk("cause", {26'h0, atom_exc_cause}, 32'h3);
      end
    end
  endtask
  task automatic t_store;
    sr(2'h1, 8'h63, 32'h15);
    atom(2'h3, 32'h5A5A0001, 0);
    chk("bus match", o, 32'hA0000002);
    atom(2'h3, 32'h5A5A0002, 0);
    chk("bus store", o, 32'h5A5A0001);
    atom(2'h3, 32'h5A5A0003, 0);
    chk("bus keep", o, 32'h5A5A0001);
    sr(2'h1, 8'h0C, 32'h5A5A0001);
    sr(2'h1, 8'h63, 32'h2A);
    atom(2'h1, 32'h00000077, 0);
    chk("cache match", o, 32'h5A5A0001);
    atom(2'h2, 32'h00000078, 0);
    chk("cache store", o, 32'h00000077);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_local;
    t_route;
    t_store;
    print_verdict;
  end
  initial
  begin
    #200000;
    bad_count++;
    print_verdict;
  end
endmodule // acsu_top_tb
`default_nettype wire
